// *** bvsl_top.sv ***
// serial six-bit volume register with strobe latch and mode tracking
// assumes all pins are asynchronous to ref_clk and are sampled at 25 MHz
//
// Functional notes
// - shift clock rising edge captures serial data, high is one, low zero
// - extra bits keep shifting; only last six bits remain
// - strobe low copies shift register into latch that drives the setting
// - strobe high holds latched setting regardless of data or clock
// - setting is a six-bit unsigned code, 64 steps
// - clock high with strobe low clears register to zero
// - contents retained in standby while supply stays at least 2 V
// - writes and clear accepted in standby as in normal operation
// - leaving standby resumes the mode active before standby
`timescale 1ns/10ps
module bvsl_top (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        volume_serial_in,
    input  wire logic        volume_shift_clock,
    input  wire logic        volume_strobe_n,
    input  wire logic        mode_select_a,
    input  wire logic        mode_select_b,
    input  wire logic        discharge_control,
    input  wire logic        supply_ok,
    output logic      [5:0]  volume_setting,
    output logic             volume_valid,
    output logic      [2:0]  shift_depth,
    output logic      [1:0]  mode_state,
    output logic             step_up_enable,
    output logic             regulator_s_enable,
    output logic             rail_short
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_reg <= bvsl_pkg::RST_SYNC_RESET;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    bvsl_pkg::bvsl_serial_t serial_raw;
    bvsl_pkg::bvsl_serial_t serial_s;
    bvsl_pkg::bvsl_ctrl_t   ctrl_raw;
    bvsl_pkg::bvsl_ctrl_t   ctrl_s;
    logic [bvsl_pkg::PIN_COUNT-1:0] pins_sync;

    assign serial_raw = '{serial_in:   volume_serial_in,
                          shift_clock: volume_shift_clock,
                          strobe_n:    volume_strobe_n};
    assign ctrl_raw   = '{select_a:  mode_select_a,
                          select_b:  mode_select_b,
                          discharge: discharge_control,
                          supply_ok: supply_ok};

    bvsl_sync #(
        .WIDTH     (bvsl_pkg::PIN_COUNT),
        .RESET_VAL ({bvsl_pkg::SERIAL_RESET, bvsl_pkg::CTRL_RESET})
    ) u_pin_sync (
        .clk       (ref_clk),
        .rst_n     (rst_n),
        .async_in  ({serial_raw, ctrl_raw}),
        .sync_out  (pins_sync)
    );

    assign serial_s = pins_sync[6:4];
    assign ctrl_s   = pins_sync[3:0];

    // ------------------------------------------------------------
    // shift clock edge detection
    // ------------------------------------------------------------
    logic clk_prev_reg;
    logic clk_rise;
    logic clear_cond;
    logic strobe_active;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_reg <= 1'b0;
        end else begin
            clk_prev_reg <= serial_s.shift_clock;
        end
    end

    assign clk_rise      = serial_s.shift_clock & ~clk_prev_reg;
    // data and clock pass the same synchroniser, so data is aligned with the edge
    assign strobe_active = ~serial_s.strobe_n;
    assign clear_cond    = serial_s.shift_clock & strobe_active;

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    logic [5:0] shift_reg;
    logic [5:0] shift_next;
    logic [2:0] depth_reg;
    logic [2:0] depth_next;

    function automatic logic [2:0] depth_inc(input logic [2:0] d);
        depth_inc = (d == bvsl_pkg::SHIFT_FULL) ? d : 3'(d + 3'h1);
    endfunction : depth_inc

    always_comb begin
        shift_next = shift_reg;
        depth_next = depth_reg;
        if (clear_cond) begin
            shift_next = bvsl_pkg::VOL_MIN;
            depth_next = bvsl_pkg::SHIFT_EMPTY;
        end else if (clk_rise) begin
            shift_next = {shift_reg[4:0], serial_s.serial_in};
            depth_next = depth_inc(depth_reg);
        end
    end

    // shifting does not depend on mode: works in standby too
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= bvsl_pkg::VOL_RESET;
            depth_reg <= bvsl_pkg::SHIFT_EMPTY;
        end else begin
            shift_reg <= shift_next;
            depth_reg <= depth_next;
        end
    end

    // ------------------------------------------------------------
    // latch and setting output
    // ------------------------------------------------------------
    logic [5:0] latch_reg;
    logic [5:0] latch_next;

    always_comb begin
        latch_next = latch_reg;
        if (clear_cond) begin
            latch_next = bvsl_pkg::VOL_MIN;
        end else if (strobe_active) begin
            latch_next = shift_reg;
        end
    end

    // retention: contents kept through standby; only supply loss spoils them
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= bvsl_pkg::VOL_RESET;
        end else begin
            latch_reg <= latch_next;
        end
    end

    assign volume_setting = latch_reg;

    // ------------------------------------------------------------
    // validity of the held code
    // ------------------------------------------------------------
    logic valid_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_reg <= 1'b0;
        end else if (!ctrl_s.supply_ok) begin
            valid_reg <= 1'b0;
        end else if (clear_cond || strobe_active) begin
            valid_reg <= 1'b1;
        end
    end

    assign volume_valid = valid_reg;
    assign shift_depth  = depth_reg;

    // ------------------------------------------------------------
    // mode tracking
    // ------------------------------------------------------------
    bvsl_pkg::bvsl_mode_t mode_reg;
    bvsl_pkg::bvsl_mode_t mode_next;
    bvsl_pkg::bvsl_mode_t prior_reg;
    bvsl_pkg::bvsl_mode_t prior_next;
    bvsl_pkg::bvsl_mode_t decoded;

    function automatic bvsl_pkg::bvsl_mode_t decode_mode(input bvsl_pkg::bvsl_ctrl_t c);
        if (c.select_a && !c.discharge) begin
            decode_mode = bvsl_pkg::BVSL_MODE_STANDBY;
        end else if (!c.select_a && !c.select_b && c.discharge) begin
            decode_mode = bvsl_pkg::BVSL_MODE_NORMAL;
        end else if (!c.select_a && c.select_b && !c.discharge) begin
            decode_mode = bvsl_pkg::BVSL_MODE_ICON;
        end else begin
            decode_mode = bvsl_pkg::BVSL_MODE_NONE;
        end
    endfunction : decode_mode

    assign decoded = decode_mode(ctrl_s);

    always_comb begin
        mode_next  = mode_reg;
        prior_next = prior_reg;
        unique case (mode_reg)
            bvsl_pkg::BVSL_MODE_STANDBY: begin
                // any non-standby code resumes the earlier mode; with no earlier mode, only a NORMAL or ICON code cancels standby
                if (decoded != bvsl_pkg::BVSL_MODE_STANDBY) begin
                    if (prior_reg != bvsl_pkg::BVSL_MODE_NONE) begin
                        mode_next = prior_reg;
                    end else if (decoded != bvsl_pkg::BVSL_MODE_NONE) begin
                        mode_next = decoded;
                    end
                end
            end
            bvsl_pkg::BVSL_MODE_NORMAL,
            bvsl_pkg::BVSL_MODE_ICON: begin
                if (decoded == bvsl_pkg::BVSL_MODE_STANDBY) begin
                    prior_next = mode_reg;
                    mode_next  = decoded;
                end else if (decoded != bvsl_pkg::BVSL_MODE_NONE) begin
                    mode_next = decoded;
                end
            end
            default: begin
                mode_next = bvsl_pkg::BVSL_MODE_STANDBY;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg  <= bvsl_pkg::BVSL_MODE_STANDBY;
            prior_reg <= bvsl_pkg::BVSL_MODE_NONE;
        end else begin
            mode_reg  <= mode_next;
            prior_reg <= prior_next;
        end
    end

    // ------------------------------------------------------------
    // mode outputs, registered
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_state         <= bvsl_pkg::BVSL_MODE_STANDBY;
            step_up_enable     <= 1'b0;
            regulator_s_enable <= 1'b0;
            rail_short         <= 1'b1;
        end else begin
            mode_state         <= mode_next;
            step_up_enable     <= (mode_next == bvsl_pkg::BVSL_MODE_NORMAL);
            regulator_s_enable <= (mode_next == bvsl_pkg::BVSL_MODE_NORMAL) ||
                                  (mode_next == bvsl_pkg::BVSL_MODE_ICON);
            rail_short         <= (mode_next == bvsl_pkg::BVSL_MODE_STANDBY);
        end
    end

endmodule : bvsl_top

// *** bvsl_pkg.sv ***
// shared constants and types of the bias volume serial latch
// assumes a single ref_clk domain; all pins but reset_n enter through bvsl_sync
package bvsl_pkg;

    // ------------------------------------------------------------
    // volume code
    // ------------------------------------------------------------
    localparam int          VOL_WIDTH = 6;
    localparam int          VOL_STEPS = 64;
    localparam logic [5:0]  VOL_MIN   = 6'h00;
    localparam logic [5:0]  VOL_MAX   = 6'h3F;
    localparam logic [5:0]  VOL_RESET = 6'h00;
    localparam logic [2:0]  SHIFT_FULL = 3'h6;
    localparam logic [2:0]  SHIFT_EMPTY = 3'h0;

    // ------------------------------------------------------------
    // synchroniser layout
    // ------------------------------------------------------------
    localparam int          PIN_COUNT = 7;
    localparam logic [1:0]  RST_SYNC_RESET = 2'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BVSL_MODE_NORMAL  = 2'b00,
        BVSL_MODE_ICON    = 2'b01,
        BVSL_MODE_STANDBY = 2'b10,
        BVSL_MODE_NONE    = 2'b11
    } bvsl_mode_t;

    typedef struct packed {
        logic serial_in;
        logic shift_clock;
        logic strobe_n;
    } bvsl_serial_t;

    typedef struct packed {
        logic select_a;
        logic select_b;
        logic discharge;
        logic supply_ok;
    } bvsl_ctrl_t;

    localparam bvsl_serial_t SERIAL_RESET = '{serial_in: 1'b0, shift_clock: 1'b0,
                                              strobe_n: 1'b1};
    localparam bvsl_ctrl_t   CTRL_RESET   = '{select_a: 1'b1, select_b: 1'b0,
                                              discharge: 1'b0, supply_ok: 1'b0};

endpackage : bvsl_pkg

// *** bvsl_sync.sv ***
// two flip-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to clk; reset value given by parameter
`timescale 1ns/10ps
module bvsl_sync #(
    parameter int                  WIDTH     = 7,
    parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [WIDTH-1:0]  async_in,
    output logic      [WIDTH-1:0]  sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    // ------------------------------------------------------------
    // first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= RESET_VAL;
            sync_out   <= RESET_VAL;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end

endmodule : bvsl_sync

// *** bvsl_assertions.sv ***
// port assertions for the volume latch
// assumes bind into bvsl_top; pin effects land a few ref_clk edges late
`timescale 1ns/10ps
module bvsl_assertions (
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic       volume_shift_clock,
    input wire logic       volume_strobe_n,
    input wire logic       mode_select_a,
    input wire logic       discharge_control,
    input wire logic       supply_ok,
    input wire logic [5:0] volume_setting,
    input wire logic       volume_valid,
    input wire logic [2:0] shift_depth,
    input wire logic [1:0] mode_state,
    input wire logic       step_up_enable,
    input wire logic       rail_short
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_clear_zero: assert property (
        ($past(volume_shift_clock, 5) && !$past(volume_strobe_n, 5) && $past(volume_shift_clock, 6)
         && !$past(volume_strobe_n, 6)) |-> volume_setting == 6'h00) else $error("clear missed");
    a_hold_latch: assert property (
        ($past(volume_strobe_n, 1) && $past(volume_strobe_n, 2) && $past(volume_strobe_n, 3)
         && $past(volume_strobe_n, 4) && $past(volume_strobe_n, 5) && $past(volume_strobe_n, 6))
        |-> $stable(volume_setting)) else $error("latch moved with strobe high");
    a_depth_sat: assert property (shift_depth <= 3'h6) else $error("depth above six");
    a_depth_step: assert property (
        $changed(shift_depth) |-> (shift_depth == $past(shift_depth) + 3'h1 || shift_depth == 3'h0))
        else $error("depth jumped");
    a_valid_drop: assert property (
        (!$past(supply_ok, 1) && !$past(supply_ok, 2) && !$past(supply_ok, 3)
         && !$past(supply_ok, 4) && !$past(supply_ok, 5) && !$past(supply_ok, 6)) |-> !volume_valid)
        else $error("valid with supply low");
    a_standby_decode: assert property (
        ($past(mode_select_a, 3) && !$past(discharge_control, 3) && $past(mode_select_a, 4)
         && !$past(discharge_control, 4)) |-> mode_state == bvsl_pkg::BVSL_MODE_STANDBY)
        else $error("standby not entered");
    a_rail_mode: assert property (rail_short == (mode_state == bvsl_pkg::BVSL_MODE_STANDBY))
        else $error("rail short mismatch");
    a_step_mode: assert property (step_up_enable |-> mode_state == bvsl_pkg::BVSL_MODE_NORMAL)
        else $error("step up outside normal");
    a_mode_legal: assert property (mode_state != bvsl_pkg::BVSL_MODE_NONE)
        else $error("illegal mode");
endmodule : bvsl_assertions

bind bvsl_top bvsl_assertions bvsl_assertions_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .volume_shift_clock(volume_shift_clock),
    .volume_strobe_n(volume_strobe_n), .mode_select_a(mode_select_a),
    .discharge_control(discharge_control), .supply_ok(supply_ok),
    .volume_setting(volume_setting), .volume_valid(volume_valid), .shift_depth(shift_depth),
    .mode_state(mode_state), .step_up_enable(step_up_enable), .rail_short(rail_short)
);

// *** bvsl_host_model.sv ***
// host controller driving the serial volume pins
// assumes ref_clk of 40 ns; shift clock of 320 ns only within frames
`timescale 1ns/10ps
module bvsl_host_model (
    input wire logic         ref_clk,
    output bvsl_pkg::bvsl_serial_t pins
);
    initial pins = bvsl_pkg::SERIAL_RESET;
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wt
    task automatic send(input logic [7:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            pins.serial_in = bits[i];
            wt(4);
            pins.shift_clock = 1'b1;
            wt(4);
            pins.shift_clock = 1'b0;
        end
        pins.serial_in = 1'b0;
    endtask : send
    task automatic strobe;
        pins.strobe_n = 1'b0;
        wt(6);
        pins.strobe_n = 1'b1;
        wt(6);
    endtask : strobe
    // pre_low leaves the strobe low before the clock rises
    task automatic clear(input logic pre_low);
        pins.strobe_n = ~pre_low;
        wt(2);
        pins.shift_clock = 1'b1;
        pins.strobe_n = 1'b0;
        wt(6);
        pins.strobe_n = 1'b1;
        wt(2);
        pins.shift_clock = 1'b0;
        wt(6);
    endtask : clear
endmodule : bvsl_host_model

// *** tb_top.sv ***
// self-checking bench for bvsl_top
// assumes bvsl_host_model drives the serial pins
`timescale 1ns/10ps
module tb_top;
    logic                   ref_clk = 1'b0;
    logic                   reset_n = 1'b0;
    logic                   mode_select_a = 1'b1;
    logic                   mode_select_b = 1'b0;
    logic                   discharge_control = 1'b0;
    logic                   supply_ok = 1'b1;
    bvsl_pkg::bvsl_serial_t host_pins;
    logic [5:0]             volume_setting;
    logic [2:0]             shift_depth;
    logic [1:0]             mode_state;
    logic                   volume_valid;
    logic                   step_up_enable;
    logic                   regulator_s_enable;
    logic                   rail_short;
    int                     failures = 0;
    int                     tests_run = 0;
    always #20 ref_clk = ~ref_clk;
    bvsl_host_model bvsl_host_model_inst (.ref_clk(ref_clk), .pins(host_pins));
    bvsl_top bvsl_top_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .volume_serial_in(host_pins.serial_in),
        .volume_shift_clock(host_pins.shift_clock), .volume_strobe_n(host_pins.strobe_n),
        .mode_select_a(mode_select_a), .mode_select_b(mode_select_b),
        .discharge_control(discharge_control), .supply_ok(supply_ok),
        .volume_setting(volume_setting), .volume_valid(volume_valid),
        .shift_depth(shift_depth), .mode_state(mode_state), .step_up_enable(step_up_enable),
        .regulator_s_enable(regulator_s_enable), .rail_short(rail_short)
    );
    task automatic check(input string what, input logic [5:0] exp, input logic [5:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic set_mode(input logic a, input logic b, input logic dc);
        @(negedge ref_clk);
        mode_select_a = a;
        mode_select_b = b;
        discharge_control = dc;
        repeat (8) @(negedge ref_clk);
    endtask : set_mode
    task automatic t_write;
        bvsl_host_model_inst.send(8'h2D, 6);
        check("depth", 6'h06, {3'h0, shift_depth});
        bvsl_host_model_inst.strobe();
        check("setting", 6'h2D, volume_setting);
        bvsl_host_model_inst.send(8'hB2, 8);
        check("depth", 6'h06, {3'h0, shift_depth});
        bvsl_host_model_inst.strobe();
        check("setting", 6'h32, volume_setting);
    endtask : t_write
    task automatic t_hold;
        bvsl_host_model_inst.send(8'h3F, 6);
        check("setting", 6'h32, volume_setting);
        bvsl_host_model_inst.strobe();
        check("setting", 6'h3F, volume_setting);
    endtask : t_hold
    task automatic t_clear(input logic pre_low);
        bvsl_host_model_inst.clear(pre_low);
        check("setting", 6'h00, volume_setting);
        check("depth", 6'h00, {3'h0, shift_depth});
        check("valid", 6'h01, {5'h00, volume_valid});
    endtask : t_clear
    task automatic t_modes;
        set_mode(1'b0, 1'b0, 1'b1);
        check("mode", {4'h0, bvsl_pkg::BVSL_MODE_NORMAL}, {4'h0, mode_state});
        check("step_up", 6'h01, {5'h00, step_up_enable});
        set_mode(1'b1, 1'b0, 1'b0);
        check("rail_short", 6'h01, {5'h00, rail_short});
        bvsl_host_model_inst.send(8'h15, 6);
        bvsl_host_model_inst.strobe();
        check("setting", 6'h15, volume_setting);
        set_mode(1'b0, 1'b0, 1'b0);
        check("mode", {4'h0, bvsl_pkg::BVSL_MODE_NORMAL}, {4'h0, mode_state});
        check("setting", 6'h15, volume_setting);
        set_mode(1'b0, 1'b1, 1'b0);
        check("mode", {4'h0, bvsl_pkg::BVSL_MODE_ICON}, {4'h0, mode_state});
        check("regulator_s", 6'h01, {5'h00, regulator_s_enable});
        check("step_up", 6'h00, {5'h00, step_up_enable});
    endtask : t_modes
    task automatic t_supply;
        @(negedge ref_clk);
        supply_ok = 1'b0;
        repeat (8) @(negedge ref_clk);
        check("valid", 6'h00, {5'h00, volume_valid});
        supply_ok = 1'b1;
    endtask : t_supply
    task automatic finish_test;
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        bvsl_host_model_inst.clear(1'b0);
        t_write();
        t_hold();
        t_clear(1'b0);
        t_modes();
        t_clear(1'b1);
        t_supply();
        finish_test();
    end
    initial begin
        #100000;
        failures++;
        finish_test();
    end
endmodule : tb_top
